// file: verilog/rtc_pkg.sv
// package of constants and carrier types for the transmitter control block
`default_nettype none
package rtc_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam logic [4:0] HOST_CLK_DIV = 5'h10;
  localparam logic [3:0] HOST_CLK_HALF = 4'h8;
  localparam logic [7:0] PLL_DIV_868 = 8'h40;
  localparam logic [7:0] PLL_DIV_LOW = 8'h20;
  localparam logic [7:0] DEV_DIV = 8'h80;
  localparam int unsigned GLITCH_NS = 200;
  localparam int unsigned GLITCH_CYC_I = (GLITCH_NS * (CLK_HZ / 1000000)
    + 999) / 1000;
  localparam logic [3:0] GLITCH_CYC = GLITCH_CYC_I[3:0];
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned FIFO_WIDTH = 1;

  typedef enum logic [1:0] {
    RTC_BAND_315 = 2'b00,
    RTC_BAND_434 = 2'b01,
    RTC_BAND_868 = 2'b10
  } rtc_band_e;

  typedef enum logic [2:0] {
    RTC_SLEEP = 3'b000,
    RTC_CLK_ONLY = 3'b001,
    RTC_ARMED = 3'b010,
    RTC_LATCHED = 3'b011,
    RTC_SHUTDOWN = 3'b100
  } rtc_state_e;

  typedef struct packed {
    logic pll_enable;
    logic mode;
    logic data;
  } rtc_ctl_s;

  typedef struct packed {
    logic pll_on;
    logic rf_enable;
    logic fsk;
    logic symbol;
    logic [7:0] pll_div;
    logic [7:0] dev_div;
  } rtc_rf_s;
endpackage : rtc_pkg
`default_nettype wire

// file: verilog/rtc_fifo.sv
// small synchronous fifo with valid/ready handshakes
`timescale 1ns/100ps
`default_nettype none
module rtc_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic [WIDTH-1:0] out_q, out_d;
  logic push, pop;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_o = (cnt_q != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = out_q;

  always_comb begin
    wr_d = push ? wr_q + AW'(1) : wr_q;
    rd_d = pop ? rd_q + AW'(1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
    // head word registered; a push into the head slot bypasses memory
    if (push && (wr_q == rd_d)) begin
      out_d = in_data_i;
    end else begin
      out_d = mem_q[rd_d];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      out_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  // storage needs no reset; only written words are ever read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule : rtc_fifo
`default_nettype wire

// file: verilog/rtc_sync.sv
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/100ps
`default_nettype none
module rtc_sync #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q, meta_d, sync_q, sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule : rtc_sync
`default_nettype wire

// file: verilog/rtc_ctrl.sv
// control logic of the uhf transmitter: states, keying, clocks, shutdown
`timescale 1ns/100ps
`default_nettype none
// How it works
// - mode and enable low: sleep, clock off
// - host clock is reference divided by sixteen
// - enable raises pll, clock; data sent ook
// - mode alone powers only host clock
// - first data rise latches ook or fsk
// - latch holds until enable drops low
// - after latch symbol is data xor mode
// - mode low passes, mode high inverts
// - xor glitches removed by low-pass filter
// - mode high end: rf on when data low
// - feedback divider 64 at 868, else 32
// - band pin open 315, high 434, low 868
// - fsk deviation is reference over 128
// - out of lock disables rf output
// - shutdown threshold kills all but host clock
// - host clock runs while enable or mode
// - shutdown latched until enable goes low
module rtc_ctrl
  import rtc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pll_enable_in_i,
  input wire logic mode_i,
  input wire logic data_i,
  input wire logic band_select_in_i,
  input wire logic band_select_oe_i,
  input wire logic pll_unlock_i,
  input wire logic shutdown_threshold_i,
  input wire logic mod_ready_i,
  output logic host_clock_out_o,
  output logic pll_on_o,
  output logic rf_enable_o,
  output logic fsk_o,
  output logic symbol_o,
  output logic symbol_valid_o,
  output logic [7:0] pll_div_o,
  output logic [7:0] dev_div_o,
  output logic [2:0] state_o
);
  rtc_ctl_s ctl_raw, ctl;
  logic [1:0] misc_s;
  logic unlock_s, sdwn_s, bs_lvl_s, bs_drv_s;
  rtc_state_e state_q, state_d;
  logic fsk_q, fsk_d;
  logic data_prev_q, data_prev_d;
  logic [3:0] div_q, div_d;
  logic hclk_q, hclk_d;
  logic filt_q, filt_d;
  logic [3:0] filt_cnt_q, filt_cnt_d;
  rtc_rf_s rf_q, rf_d;
  rtc_band_e band;
  logic raw_sym, clk_on, fifo_in_ready, fifo_out_valid, fifo_sym;
  logic fifo_in_valid;
  logic data_rise;

  assign ctl_raw.pll_enable = pll_enable_in_i;
  assign ctl_raw.mode = mode_i;
  assign ctl_raw.data = data_i;

  rtc_sync #(.WIDTH(3)) u_sync_ctl (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(ctl_raw),
    .sync_o(ctl)
  );

  rtc_sync #(.WIDTH(4)) u_sync_misc (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({pll_unlock_i, shutdown_threshold_i, band_select_in_i,
      band_select_oe_i}),
    .sync_o({unlock_s, sdwn_s, misc_s})
  );
  assign bs_lvl_s = misc_s[1];
  assign bs_drv_s = misc_s[0];

  // three-state pin seen as level plus a driven sense
  function automatic rtc_band_e band_of(input logic driven,
                                        input logic level);
    if (!driven) begin
      return RTC_BAND_315;
    end else if (level) begin
      return RTC_BAND_434;
    end else begin
      return RTC_BAND_868;
    end
  endfunction : band_of

  assign band = band_of(bs_drv_s, bs_lvl_s);

  // where enable falls: mode high keeps the host clock alive
  function automatic rtc_state_e idle_state(input logic mode);
    if (mode) begin
      return RTC_CLK_ONLY;
    end else begin
      return RTC_SLEEP;
    end
  endfunction : idle_state

  // pll, filter and fifo feed are live only while transmitting
  function automatic logic pll_powered(input rtc_state_e st);
    case (st)
      RTC_ARMED: begin
        return 1'b1;
      end
      RTC_LATCHED: begin
        return 1'b1;
      end
      default: begin
        return 1'b0;
      end
    endcase
  endfunction : pll_powered

  // unknown band codes fall back to the low divider
  function automatic logic [7:0] pll_div_of(input rtc_band_e b);
    case (b)
      RTC_BAND_868: begin
        return PLL_DIV_868;
      end
      RTC_BAND_434: begin
        return PLL_DIV_LOW;
      end
      RTC_BAND_315: begin
        return PLL_DIV_LOW;
      end
      default: begin
        return PLL_DIV_LOW;
      end
    endcase
  endfunction : pll_div_of

  assign data_rise = ctl.data && !data_prev_q;

  always_comb begin
    state_d = state_q;
    fsk_d = fsk_q;
    data_prev_d = ctl.data;
    case (state_q)
      RTC_SLEEP: begin
        if (ctl.pll_enable) begin
          state_d = RTC_ARMED;
        end else if (ctl.mode) begin
          state_d = RTC_CLK_ONLY;
        end
      end
      RTC_CLK_ONLY: begin
        if (ctl.pll_enable) begin
          state_d = RTC_ARMED;
        end else if (!ctl.mode) begin
          state_d = RTC_SLEEP;
        end
      end
      RTC_ARMED: begin
        fsk_d = 1'b0;
        if (!ctl.pll_enable) begin
          state_d = idle_state(ctl.mode);
        end else if (data_rise) begin
          fsk_d = ctl.mode;
          state_d = RTC_LATCHED;
        end
      end
      RTC_LATCHED: begin
        if (!ctl.pll_enable) begin
          fsk_d = 1'b0;
          state_d = idle_state(ctl.mode);
        end
      end
      RTC_SHUTDOWN: begin
        if (!ctl.pll_enable) begin
          fsk_d = 1'b0;
          state_d = idle_state(ctl.mode);
        end
      end
      default: begin
        state_d = RTC_SLEEP;
      end
    endcase
    // silent shutdown overrides any active transmit state
    if (sdwn_s && ctl.pll_enable) begin
      state_d = RTC_SHUTDOWN;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= RTC_SLEEP;
      fsk_q <= 1'b0;
      data_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      fsk_q <= fsk_d;
      data_prev_q <= data_prev_d;
    end
  end

  // host clock, also alive in shutdown
  assign clk_on = ctl.pll_enable || ctl.mode;

  always_comb begin
    div_d = div_q;
    hclk_d = 1'b0;
    if (clk_on) begin
      div_d = div_q + 4'h1;
      hclk_d = (div_q < HOST_CLK_HALF) ? 1'b1 : 1'b0;
    end else begin
      div_d = 4'h0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= 4'h0;
      hclk_q <= 1'b0;
    end else begin
      div_q <= div_d;
      hclk_q <= hclk_d;
    end
  end

  // before the latch data goes straight; after it, xor with mode
  assign raw_sym = (state_q == RTC_LATCHED) ? (ctl.data ^ ctl.mode)
    : ctl.data;

  // a change must persist GLITCH_CYC cycles; costs that much latency
  always_comb begin
    filt_d = filt_q;
    filt_cnt_d = 4'h0;
    if (raw_sym != filt_q) begin
      filt_cnt_d = filt_cnt_q + 4'h1;
      if (filt_cnt_q + 4'h1 >= GLITCH_CYC) begin
        filt_d = raw_sym;
        filt_cnt_d = 4'h0;
      end
    end
    // nothing is filtered or buffered while the pll is off
    if (!pll_powered(state_q)) begin
      filt_d = 1'b0;
      filt_cnt_d = 4'h0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filt_q <= 1'b0;
      filt_cnt_q <= 4'h0;
    end else begin
      filt_q <= filt_d;
      filt_cnt_q <= filt_cnt_d;
    end
  end

  // symbol stream samples buffered towards modulator
  assign fifo_in_valid = pll_powered(state_q);

  rtc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(filt_q),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_sym),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(mod_ready_i)
  );

  always_comb begin
    rf_d.pll_on = pll_powered(state_q);
    rf_d.rf_enable = rf_d.pll_on && !unlock_s && fifo_out_valid
      && fifo_in_ready;
    rf_d.fsk = fsk_q;
    rf_d.symbol = fifo_out_valid ? fifo_sym : 1'b0;
    rf_d.pll_div = pll_div_of(band);
    rf_d.dev_div = DEV_DIV;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rf_q <= '0;
    end else begin
      rf_q <= rf_d;
    end
  end

  assign host_clock_out_o = hclk_q;
  assign pll_on_o = rf_q.pll_on;
  assign rf_enable_o = rf_q.rf_enable;
  assign fsk_o = rf_q.fsk;
  assign symbol_o = rf_q.symbol;
  assign symbol_valid_o = fifo_out_valid;
  assign pll_div_o = rf_q.pll_div;
  assign dev_div_o = rf_q.dev_div;
  assign state_o = state_q;
endmodule : rtc_ctrl
`default_nettype wire

// file: bench/rtc_ctrl_checker.sv
// port assertions for the transmitter control block
`timescale 1ns/100ps
`default_nettype none
module rtc_ctrl_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pll_enable_in_i,
  input wire logic mode_i,
  input wire logic band_select_in_i,
  input wire logic band_select_oe_i,
  input wire logic pll_unlock_i,
  input wire logic host_clock_out_o,
  input wire logic pll_on_o,
  input wire logic rf_enable_o,
  input wire logic fsk_o,
  input wire logic [7:0] pll_div_o,
  input wire logic [7:0] dev_div_o,
  input wire logic [2:0] state_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_idle;
    (!pll_enable_in_i && !mode_i) [*5];
  endsequence
  sequence s_half;
    host_clock_out_o [*8] ##1 !host_clock_out_o;
  endsequence
  property p_sleep;
    s_idle |-> state_o == 3'h0 && !host_clock_out_o;
  endproperty
  // cut short when the clock is switched off mid-phase
  property p_clk;
    disable iff (!rst_n_i || state_o == 3'h0)
    $rose(host_clock_out_o) |-> s_half;
  endproperty
  property p_clk_only;
    state_o == 3'h1 [*2] |-> !pll_on_o;
  endproperty
  property p_arm;
    state_o == 3'h2 [*2] |-> pll_on_o;
  endproperty
  property p_hold;
    state_o == 3'h3 [*3] |-> $stable(fsk_o);
  endproperty
  property p_lock;
    pll_unlock_i [*5] |-> !rf_enable_o;
  endproperty
  property p_shut;
    state_o == 3'h4 [*2] |-> !pll_on_o && !rf_enable_o;
  endproperty
  property p_band;
    (band_select_oe_i && !band_select_in_i) [*6] |-> pll_div_o == 8'h40;
  endproperty
  property p_dev;
    pll_on_o |-> dev_div_o == 8'h80;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
  a_clk: assert property (p_clk) else $error("host clock period");
  a_clk_only: assert property (p_clk_only) else $error("pll on");
  a_arm: assert property (p_arm) else $error("pll off when armed");
  a_hold: assert property (p_hold) else $error("keying changed");
  a_lock: assert property (p_lock) else $error("rf on unlocked");
  a_shut: assert property (p_shut) else $error("on in shutdown");
  a_band: assert property (p_band) else $error("divider not 64");
  a_dev: assert property (p_dev) else $error("deviation divider");
endmodule : rtc_ctrl_checker
bind rtc_ctrl rtc_ctrl_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .pll_enable_in_i(pll_enable_in_i), .mode_i(mode_i),
  .band_select_in_i(band_select_in_i), .band_select_oe_i(band_select_oe_i),
  .pll_unlock_i(pll_unlock_i), .host_clock_out_o(host_clock_out_o),
  .pll_on_o(pll_on_o), .rf_enable_o(rf_enable_o), .fsk_o(fsk_o),
  .pll_div_o(pll_div_o), .dev_div_o(dev_div_o), .state_o(state_o));
`default_nettype wire

// file: bench/rtc_host_model.sv
// host controller model driving the enable, mode and data pins
`timescale 1ns/100ps
`default_nettype none
module rtc_host_model (
  input wire logic clk_i,
  output logic pll_enable_o,
  output logic mode_o,
  output logic data_o
);
  initial {pll_enable_o, mode_o, data_o} = 3'h0;
  // mode and data move on one edge, so falling edges stay aligned
  task automatic drive(input logic en, input logic m, input logic d);
    @(negedge clk_i);
    // mode rises a cycle ahead of enable dropping
    if (!en && pll_enable_o && m && !mode_o) begin
      mode_o = 1'b1;
      @(negedge clk_i);
    end
    mode_o = m;
    data_o = d;
    pll_enable_o = en;
  endtask : drive
endmodule : rtc_host_model
`default_nettype wire

// file: bench/rtc_ctrl_tb_top.sv
// self-checking bench for the transmitter control block
`timescale 1ns/100ps
`default_nettype none
module rtc_ctrl_tb_top;
  import rtc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic band_i = 1'b0, band_oe = 1'b0, unlock = 1'b0, shut = 1'b0;
  logic mod_rdy = 1'b1;
  logic band_tie = 1'b0;
  wire logic en, mo, da;
  wire logic band_pin;
  logic host_clk, pll_on, rf_en, fsk, sym, sym_v;
  logic [7:0] pll_div, dev_div;
  logic [2:0] state;
  logic [31:0] r;
  int n_errors = 0, check_count = 0, seed = 32'hd068;
  int latched = 0, efsk = 0, pd = 0, sd = 0, es = 0, hc = 0;
  always #25 clk_i = ~clk_i;
  // band pin strapped to the enable line avoids bias current in sleep
  assign band_pin = band_tie ? en : band_i;
  rtc_host_model u_host (.clk_i(clk_i), .pll_enable_o(en), .mode_o(mo),
    .data_o(da));
  rtc_ctrl u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .pll_enable_in_i(en),
    .mode_i(mo), .data_i(da), .band_select_in_i(band_pin),
    .band_select_oe_i(band_oe), .pll_unlock_i(unlock),
    .shutdown_threshold_i(shut), .mod_ready_i(mod_rdy),
    .host_clock_out_o(host_clk), .pll_on_o(pll_on), .rf_enable_o(rf_en),
    .fsk_o(fsk), .symbol_o(sym), .symbol_valid_o(sym_v),
    .pll_div_o(pll_div), .dev_div_o(dev_div), .state_o(state));
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %b got %b", nm, e, g);
    end
  endtask : cmp_bit
  task automatic cmp_byte(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : cmp_byte
  // 80 cycles covers sync, filter and a fifo of 32
  task automatic apply(input logic e, input logic m, input logic d);
    u_host.drive(e, m, d);
    if (!e) begin
      latched = 0;
      sd = 0;
    end else if (shut) sd = 1;
    else if (!latched && d && !pd) begin
      latched = 1;
      efsk = m;
    end
    pd = d;
    repeat (80) @(negedge clk_i);
    hc = 0;
    repeat (32) begin
      @(negedge clk_i);
      if (host_clk === 1'b1) hc++;
    end
    cmp_byte("clk", (e || m) ? 8'h10 : 8'h00, hc[7:0]);
    es = !e ? (m ? 1 : 0) : sd ? 4 : latched ? 3 : 2;
    cmp_byte("state", es[7:0], {5'h0, state});
    cmp_bit("pll on", es == 2 || es == 3, pll_on);
    if (e && !sd) begin
      cmp_byte("div", (band_oe && !band_i) ? 8'h40 : 8'h20, pll_div);
      cmp_byte("dev", 8'h80, dev_div);
    end
    if (latched && e && !sd) begin
      cmp_bit("fsk", efsk[0], fsk);
      cmp_bit("symbol", d ^ m, sym);
      if (mod_rdy && !unlock) cmp_bit("rf", 1'b1, rf_en);
    end else if (e && !sd) cmp_bit("symbol", d, sym);
  endtask : apply
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    apply(0, 0, 0);
    apply(0, 1, 0);
    $display("test sleep and clock only done");
    for (int b = 0; b < 3; b++) begin
      band_oe = (b != 0); // open, high, grounded
      band_i = (b == 1);
      band_tie = (b == 1);
      apply(1, 0, 0);
      apply(1, 0, 1);
      repeat (4) begin
        r = $random(seed);
        apply(1, 0, r[0]);
      end
      apply(1, 1, 0);
      apply(0, 1, 0);
      $display("test band %0d done", b);
    end
    apply(1, 1, 0);
    apply(1, 1, 1);
    repeat (6) begin
      r = $random(seed);
      apply(1, r[1], r[0]);
    end
    unlock = 1'b1;
    apply(1, 0, 1);
    cmp_bit("rf unlocked", 1'b0, rf_en);
    unlock = 1'b0;
    mod_rdy = 1'b0;
    apply(1, 0, 1);
    cmp_bit("rf full", 1'b0, rf_en);
    mod_rdy = 1'b1;
    apply(0, 1, 0);
    cmp_bit("valid empty", 1'b0, sym_v);
    $display("test fsk, lock and fifo done");
    apply(1, 0, 0);
    shut = 1'b1;
    apply(1, 0, 0);
    shut = 1'b0;
    apply(1, 0, 0);
    apply(0, 1, 0);
    apply(1, 0, 0);
    $display("test shutdown done");
    print_verdict();
  end
  // tests need about 5000 cycles; four times that means a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    print_verdict();
  end
endmodule : rtc_ctrl_tb_top
`default_nettype wire
